// [cso_timing_regs.sv]
// hs timing override register bank with burst-aligned effective timing
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - force bit 7 of the hs zero register selects bits 6:0 over the auto value.
// - force bit 7 of the hs trail register selects bits 6:0 over the auto value.
// - force bit 7 of the hs exit register selects bits 6:0 over the auto value.
// - force bit 7 of the plx register selects bits 6:0 over the auto value.
// - with force clear the value field ignores writes and reads the auto value.
// - with force set the value field takes writes and reads back the last write.
// - after reset every force bit reads 0 so all four select auto timing; the eff outputs stay 0 until the first burst_start.
// - the bank answers only on page 0x00 at register numbers 0x45 to 0x48.
module cso_timing_regs (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_page,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [6:0] auto_hs_zero,
  input  wire logic [6:0] auto_hs_trail,
  input  wire logic [6:0] auto_hs_exit,
  input  wire logic [6:0] auto_plx,
  input  wire logic       burst_start,
  output logic      [6:0] eff_hs_zero,
  output logic      [6:0] eff_hs_trail,
  output logic      [6:0] eff_hs_exit,
  output logic      [6:0] eff_plx
);

  logic [3:0] force_ff;
  logic [6:0] value_ff [4];
  logic [6:0] auto_val [4];
  logic [6:0] sel_val  [4];
  logic [6:0] eff_ff   [4];
  logic [3:0] hit;
  logic       page_ok;
  logic [7:0] nxt_rdata;

  assign auto_val[cso_pkg::IDX_ZERO]  = auto_hs_zero;
  assign auto_val[cso_pkg::IDX_TRAIL] = auto_hs_trail;
  assign auto_val[cso_pkg::IDX_EXIT]  = auto_hs_exit;
  assign auto_val[cso_pkg::IDX_PLX]   = auto_plx;

  assign page_ok = (reg_page == cso_pkg::PAGE_TIMING);
  assign hit[cso_pkg::IDX_ZERO]  =
    page_ok && (reg_addr == cso_pkg::REG_HS_ZERO);
  assign hit[cso_pkg::IDX_TRAIL] =
    page_ok && (reg_addr == cso_pkg::REG_HS_TRAIL);
  assign hit[cso_pkg::IDX_EXIT]  =
    page_ok && (reg_addr == cso_pkg::REG_HS_EXIT);
  assign hit[cso_pkg::IDX_PLX]   =
    page_ok && (reg_addr == cso_pkg::REG_PLX);

  genvar gi;
  generate
    for (gi = 0; gi < cso_pkg::NUM_TM; gi++) begin : g_tm
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          force_ff[gi] <= cso_pkg::RST_FORCE;
        end else if (reg_wr && hit[gi]) begin
          force_ff[gi] <= reg_wdata[cso_pkg::FORCE_BIT];
        end
      end

      // field writable only while force is set before this write
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          value_ff[gi] <= cso_pkg::RST_VALUE;
        end else if (reg_wr && hit[gi] && force_ff[gi]) begin
          value_ff[gi] <= reg_wdata[cso_pkg::VAL_MSB:0];
        end
      end

      // selected value: forced field or live auto value
      assign sel_val[gi] = force_ff[gi] ? value_ff[gi] : auto_val[gi];

      // held between bursts so a burst in flight never sees a change
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          eff_ff[gi] <= cso_pkg::RST_VALUE;
        end else if (burst_start) begin
          eff_ff[gi] <= sel_val[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_rdata = cso_pkg::RD_IDLE;
    for (int i = 0; i < cso_pkg::NUM_TM; i++) begin
      if (hit[i]) begin
        nxt_rdata = {force_ff[i], sel_val[i]};
      end
    end
  end

  // unmapped reads return zero; data stands only the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= cso_pkg::RD_IDLE;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= cso_pkg::RD_IDLE;
    end
  end

  assign eff_hs_zero  = eff_ff[cso_pkg::IDX_ZERO];
  assign eff_hs_trail = eff_ff[cso_pkg::IDX_TRAIL];
  assign eff_hs_exit  = eff_ff[cso_pkg::IDX_EXIT];
  assign eff_plx      = eff_ff[cso_pkg::IDX_PLX];

endmodule
`default_nettype wire

// [cso_pkg.sv]
// shared constants for the hs timing override register bank
package cso_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned VAL_W  = 7;
  localparam int unsigned NUM_TM = 4;

  localparam logic [7:0] PAGE_TIMING = 8'h00;

  localparam logic [7:0] REG_HS_ZERO  = 8'h45;
  localparam logic [7:0] REG_HS_TRAIL = 8'h46;
  localparam logic [7:0] REG_HS_EXIT  = 8'h47;
  localparam logic [7:0] REG_PLX      = 8'h48;

  localparam int unsigned FORCE_BIT = 7;
  localparam int unsigned VAL_MSB   = 6;

  localparam logic       RST_FORCE = 1'b0;
  localparam logic [6:0] RST_VALUE = 7'h00;
  localparam logic [7:0] RD_IDLE   = 8'h00;

  localparam int unsigned IDX_ZERO  = 0;
  localparam int unsigned IDX_TRAIL = 1;
  localparam int unsigned IDX_EXIT  = 2;
  localparam int unsigned IDX_PLX   = 3;
endpackage

// [cso_timing_regs_monitor.sv]
// checks on the hs zero register and its read port
`timescale 1ns/1ps
`default_nettype none
module cso_timing_regs_monitor (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [6:0] auto_hs_zero,
  input wire logic       burst_start,
  input wire logic [6:0] eff_hs_zero
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [7:0] fv_ff;
  // model tracks the zero register only; other pages never touch it
  wire logic  hit = (reg_page == 8'h00) && (reg_addr == 8'h45);
  always_ff @(posedge mclk)
    if (!reset_n) fv_ff <= 8'h00;
    else if (hit && reg_wr)
      fv_ff <= fv_ff[7] ? reg_wdata : {reg_wdata[7], fv_ff[6:0]};
  a_rd_auto: assert property (reg_rd && hit && !fv_ff[7] |=>
    reg_rdata == {1'b0, $past(auto_hs_zero)}) else $error("rd auto");
  a_rd_force: assert property (reg_rd && hit && fv_ff[7] |=>
    reg_rdata == $past(fv_ff)) else $error("rd force");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("rd idle");
  a_rd_unmap: assert property (reg_rd && reg_addr > 8'h48 |=>
    reg_rdata == 8'h00) else $error("rd unmap");
  a_rd_page: assert property (reg_rd && reg_page != 8'h00 |=>
    reg_rdata == 8'h00) else $error("rd page");
  a_eff_auto: assert property (burst_start && !fv_ff[7] |=>
    eff_hs_zero == $past(auto_hs_zero)) else $error("eff auto");
  a_eff_force: assert property (burst_start && fv_ff[7] |=>
    eff_hs_zero == $past(fv_ff[6:0])) else $error("eff force");
  a_eff_hold: assert property (!burst_start |=> $stable(eff_hs_zero))
    else $error("eff hold");
  a_rst_clear: assert property ($rose(reset_n) |-> !eff_hs_zero)
    else $error("reset");
endmodule
bind cso_timing_regs cso_timing_regs_monitor i_mon (.mclk, .reset_n,
  .reg_page, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .auto_hs_zero,
  .burst_start, .eff_hs_zero);
`default_nettype wire

// [cso_timing_regs_tb.sv]
// bench for the hs timing override bank
`timescale 1ns/1ps
`default_nettype none
module cso_timing_regs_tb;
  logic        mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, burst_start = 0;
  logic [7:0]  reg_page = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [6:0]  au = 7'h2a, eff_hs_zero, eff_hs_trail, eff_hs_exit, eff_plx;
  wire logic [27:0] effs = {eff_plx, eff_hs_exit, eff_hs_trail, eff_hs_zero};
  // address, write byte, expected timing
  logic [23:0] rows [4] = '{24'h459515, 24'h46a222, 24'h47ff7f, 24'h488101};
  int          fails = 0, check_count = 0;
  initial forever #2 mclk = ~mclk;
  cso_timing_regs i_cso_timing_regs (.mclk, .reset_n, .reg_page, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .auto_hs_zero(au),
    .auto_hs_trail(au), .auto_hs_exit(au), .auto_plx(au), .burst_start,
    .eff_hs_zero, .eff_hs_trail, .eff_hs_exit, .eff_plx);
  task automatic chk(input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED byte exp %h got %h", e, g);
    end
  endtask
  // one strobe cycle; read data settled just after the taking edge
  task automatic bus(input logic w, input logic [7:0] p, a, d);
    @(posedge mclk);
    {reg_wr, reg_rd, reg_page, reg_addr, reg_wdata} <= {w, !w, p, a, d};
    @(posedge mclk);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
  endtask
  task automatic rd(input logic [7:0] p, a, e);
    bus(0, p, a, 8'h00);
    chk(e, reg_rdata);
  endtask
  task automatic burst;
    @(posedge mclk) burst_start <= 1'b1;
    @(posedge mclk) burst_start <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(8'h00, 8'h45, {1'b0, au});
    foreach (rows[i]) begin
      bus(1, 8'h00, rows[i][23:16], rows[i][15:8]);
      rd(8'h00, rows[i][23:16], 8'h80); // value dropped while auto
      bus(1, 8'h00, rows[i][23:16], rows[i][15:8]);
      rd(8'h00, rows[i][23:16], rows[i][15:8]);
      burst;
      chk(rows[i][7:0], {1'b0, effs[i*7 +: 7]});
    end
    $display("table rows done");
    @(posedge mclk) au <= 7'h33;
    bus(1, 8'h00, 8'h45, 8'h00);
    chk(8'h15, {1'b0, eff_hs_zero}); // held until next burst
    burst;
    chk(8'h33, {1'b0, eff_hs_zero});
    bus(1, 8'h01, 8'h46, 8'h00);
    rd(8'h01, 8'h46, 8'h00);
    rd(8'h00, 8'h46, 8'ha2);
    rd(8'h00, 8'h49, 8'h00);
    tally_and_finish;
  end
endmodule
`default_nettype wire
